// file: verilog/psq_pkg.sv
// Package: constants and carrier types for the program sequencer
`default_nettype none
package psq_pkg;
  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int PC_W        = 12;          // Program counter width
  localparam int STK_DEPTH   = 4;           // Return stack levels
  localparam int DATA_W      = 16;          // Data bus width
  localparam int UPPER_W     = 9;           // Dedicated upper address pins
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] SYSCON_BANK = 16'h0001; // Bank of config register
  localparam logic [2:0]  SYSCON_PORT = 3'h3;     // Port of config register
  localparam int          MODE_BIT    = 0;        // Memory select bit position
  localparam logic [15:0] SYSCON_ONES = 16'hfffe; // Upper bits read as ones
  localparam logic [PC_W-1:0] PC_RST  = 12'h000;  // Reset value of counter
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          SWITCH_CYC  = 2;        // Mode switch delay, cycles
  localparam int          BRANCH_ON_INPUT_LOW_CYC    = 2;        // Absent-input branch cycles
  localparam logic [1:0]  SWITCH_CNT  = 2'(SWITCH_CYC);
  localparam logic [1:0]  NOP_CNT     = 2'(BRANCH_ON_INPUT_LOW_CYC - 1);
  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PSQ_NONE, PSQ_BRANCH, PSQ_CALL, PSQ_RET, PSQ_INTR,
    PSQ_PUSH, PSQ_POP, PSQ_TBL_START, PSQ_TBL_END, PSQ_BRANCH_ON_INPUT_LOW
  } psq_cmd_t;
  // Request from the decoder
  typedef struct packed {
    psq_cmd_t          cmd;     // Sequencer command
    logic              cond;    // Branch condition true
    logic [PC_W-1:0]   target;  // Absolute target from the instruction
  } psq_req_t;
  // Port write from the OUT instruction
  typedef struct packed {
    logic              we;      // Write strobe
    logic [15:0]       bank;    // Current bank select
    logic [2:0]        port;    // Port address
    logic [DATA_W-1:0] data;    // Write data
  } psq_io_t;
endpackage
`default_nettype wire

// file: verilog/psq_sequencer.sv
// Program counter, return stack and program memory mode select
//
// Summary of operation
// - absent-input branch acts as two-cycle no-op
// - twelve-bit counter, fetch then increment
// - reset clears the program counter
// - counter loads on output clock fall
// - counter drives upper address pins in mode zero only
// - taken branch loads absolute target, else increment
// - calls and interrupts push the counter plus one
// - stack is four levels of twelve bits
// - push places accumulator low bits on top
// - push shifts down, bottom value lost silently
// - pop moves top to accumulator, shifts up
// - pop keeps bottom level copied upward
// - table read and write use one level
// - config bit zero selects memory mode
// - mode one fetches from internal memory
// - internal mode holds upper address lines high
// - mode zero fetches externally, internal disabled
// - mode pin sampled in first cycle after reset
// - after reset pin is falling-edge interrupt
// - memory source switches two cycles after write
// - config register at bank one port three
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // Pipeline advance, one cycle per output clock falling edge
  input  wire logic                     output_clock_fall,
  // Decoder request
  input  wire psq_pkg::psq_req_t        req,
  input  wire logic [psq_pkg::PC_W-1:0] acc_low,
  input  wire logic [psq_pkg::PC_W-1:0] tbl_addr,
  // Port write and read
  input  wire psq_pkg::psq_io_t         io,
  input  wire logic                     io_rd,
  output logic [psq_pkg::DATA_W-1:0]    io_rdata,
  // Shared interrupt and mode pin
  input  wire logic                     nonmaskable_mode_pin,
  output logic                          nmi_pulse,
  // Program memory side
  output logic [psq_pkg::PC_W-1:0]      prog_addr,
  output logic [psq_pkg::UPPER_W-1:0]   ext_addr_bus,
  output logic [2:0]                    port_addr_lines,
  output logic                          int_mem_en,
  output logic                          memory_select_bit,
  // Results toward the datapath
  output logic [psq_pkg::PC_W-1:0]      pop_data,
  output logic                          pop_valid,
  output logic                          busy
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [psq_pkg::PC_W-1:0] pc_q;                      // Program counter
  logic [psq_pkg::PC_W-1:0] stk_q [psq_pkg::STK_DEPTH]; // Return stack
  logic                     mode_q;                    // Active memory mode
  logic                     mode_pend_q;               // Written mode value
  logic [1:0]               sw_cnt_q;                  // Switch delay count
  logic [1:0]               nop_cnt_q;                 // No-op stall count
  logic                     in_rst_q;                  // First cycle after reset
  logic                     pin_q;                     // Pin history for edge
  logic                     armed_q;                   // Pin seen high after reset
  logic                     tbl_q;                     // Table transfer active
  logic                     adv;                       // Pipeline step this cycle
  logic                     sys_wr;                    // Config register write
  logic                     sys_sel;                   // Config register selected

  assign adv     = output_clock_fall && (nop_cnt_q == 2'h0);
  assign sys_sel = (io.bank == psq_pkg::SYSCON_BANK) &&
                   (io.port == psq_pkg::SYSCON_PORT);
  assign sys_wr  = io.we && sys_sel;

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // Counter steps on each pipeline advance; branches load the target
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= psq_pkg::PC_RST;
    end else if (adv) begin
      unique case (req.cmd)
        psq_pkg::PSQ_BRANCH: begin
          if (req.cond) begin
            pc_q <= req.target;
          end else begin
            pc_q <= pc_q + 12'h001;
          end
        end
        psq_pkg::PSQ_CALL, psq_pkg::PSQ_INTR: begin
          pc_q <= req.target;
        end
        psq_pkg::PSQ_RET: begin
          pc_q <= stk_q[0];
        end
        psq_pkg::PSQ_TBL_START: begin
          pc_q <= tbl_addr;
        end
        psq_pkg::PSQ_TBL_END: begin
          pc_q <= stk_q[0];
        end
        default: begin
          pc_q <= pc_q + 12'h001;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // No-op stall for the absent-input branch
  // ---------------------------------------------------------------
  // The branch never takes; it holds the pipeline one extra step
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      nop_cnt_q <= 2'h0;
    end else if (adv && req.cmd == psq_pkg::PSQ_BRANCH_ON_INPUT_LOW) begin
      nop_cnt_q <= psq_pkg::NOP_CNT;
    end else if (output_clock_fall && nop_cnt_q != 2'h0) begin
      nop_cnt_q <= nop_cnt_q - 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  // Push shifts down and drops the bottom; pop shifts up keeping bottom
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < psq_pkg::STK_DEPTH; i++) begin
        stk_q[i] <= 12'h000;
      end
    end else if (adv) begin
      unique case (req.cmd)
        psq_pkg::PSQ_CALL, psq_pkg::PSQ_INTR, psq_pkg::PSQ_PUSH,
        psq_pkg::PSQ_TBL_START: begin
          for (int i = psq_pkg::STK_DEPTH - 1; i > 0; i--) begin
            stk_q[i] <= stk_q[i-1];
          end
          if (req.cmd == psq_pkg::PSQ_PUSH) begin
            stk_q[0] <= acc_low;
          end else begin
            stk_q[0] <= pc_q + 12'h001;
          end
        end
        psq_pkg::PSQ_POP, psq_pkg::PSQ_RET, psq_pkg::PSQ_TBL_END: begin
          for (int i = 0; i < psq_pkg::STK_DEPTH - 1; i++) begin
            stk_q[i] <= stk_q[i+1];
          end
          stk_q[psq_pkg::STK_DEPTH-1] <= stk_q[psq_pkg::STK_DEPTH-1];
        end
        default: begin
        end
      endcase
    end
  end

  // Popped top toward the accumulator low bits
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pop_data  <= 12'h000;
      pop_valid <= 1'b0;
    end else begin
      pop_valid <= adv && (req.cmd == psq_pkg::PSQ_POP);
      if (adv && req.cmd == psq_pkg::PSQ_POP) begin
        pop_data <= stk_q[0];
      end
    end
  end

  // Table transfer marker, holding one stack level while active
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tbl_q <= 1'b0;
    end else if (adv && req.cmd == psq_pkg::PSQ_TBL_START) begin
      tbl_q <= 1'b1;
    end else if (adv && req.cmd == psq_pkg::PSQ_TBL_END) begin
      tbl_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Memory mode
  // ---------------------------------------------------------------
  // Strap is caught in the first cycle after release, from a pin held
  // steady through reset; software writes take effect after a delay
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      in_rst_q <= 1'b1;
    end else begin
      in_rst_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q      <= 1'b0;
      mode_pend_q <= 1'b0;
      sw_cnt_q    <= 2'h0;
    end else if (in_rst_q) begin
      mode_q      <= nonmaskable_mode_pin;
      mode_pend_q <= nonmaskable_mode_pin;
    end else if (sys_wr) begin
      mode_pend_q <= io.data[psq_pkg::MODE_BIT];
      sw_cnt_q    <= psq_pkg::SWITCH_CNT - 2'h1;
    end else if (sw_cnt_q != 2'h0) begin
      sw_cnt_q <= sw_cnt_q - 2'h1;
    end else begin
      mode_q <= mode_pend_q;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt edge detect on the shared pin
  // ---------------------------------------------------------------
  // Armed only once the pin has been seen high after reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q     <= 1'b0;
      armed_q   <= 1'b0;
      nmi_pulse <= 1'b0;
    end else begin
      pin_q     <= nonmaskable_mode_pin;
      if (!in_rst_q && pin_q) begin
        armed_q <= 1'b1;
      end
      nmi_pulse <= armed_q && pin_q && !nonmaskable_mode_pin;
    end
  end

  // ---------------------------------------------------------------
  // Address outputs and read data
  // ---------------------------------------------------------------
  // Upper pins forced high in internal mode; low pins always follow pc
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prog_addr         <= 12'h000;
      ext_addr_bus      <= 9'h000;
      port_addr_lines   <= 3'h0;
      int_mem_en        <= 1'b0;
      memory_select_bit <= 1'b0;
      busy              <= 1'b0;
      io_rdata          <= 16'h0000;
    end else begin
      prog_addr       <= pc_q;
      port_addr_lines <= pc_q[2:0];
      if (mode_q) begin
        ext_addr_bus <= 9'h1ff;
      end else begin
        ext_addr_bus <= pc_q[psq_pkg::PC_W-1:3];
      end
      int_mem_en        <= mode_q;
      memory_select_bit <= mode_q;
      busy              <= (nop_cnt_q != 2'h0) || tbl_q;
      if (io_rd && sys_sel) begin
        io_rdata <= psq_pkg::SYSCON_ONES | {15'h0000, mode_pend_q};
      end else begin
        io_rdata <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/psq_prog_mem.sv
// Program memory model on the far side of the address bus
`timescale 1ns/1ps
`default_nettype none
module psq_prog_mem (
  // Clock
  input  wire logic        clock,
  // Address side
  input  wire logic [11:0] prog_addr,
  input  wire logic        int_mem_en,
  // Returned word
  output logic      [15:0] word
);
  // External memory answers only while the internal array is off
  always_ff @(posedge clock) begin
    if (!int_mem_en) begin
      word <= {4'h0, prog_addr} ^ 16'h5a5a;
    end else begin
      word <= ~word; // Released bus shows no stale value
    end
  end
endmodule
`default_nettype wire

// file: tb/psq_checker.sv
// Checker: sequencer port assertions and bind
`timescale 1ns/1ps
`default_nettype none
module psq_checker (
  // Clock and reset
  input wire logic              clock,
  input wire logic              sys_rst,
  // Inputs
  input wire logic              output_clock_fall,
  input wire psq_pkg::psq_req_t req,
  input wire psq_pkg::psq_io_t  io,
  input wire logic              io_rd,
  input wire logic              nonmaskable_mode_pin,
  // Outputs
  input wire logic [15:0]       io_rdata,
  input wire logic              nmi_pulse,
  input wire logic [11:0]       prog_addr,
  input wire logic [8:0]        ext_addr_bus,
  input wire logic [2:0]        port_addr_lines,
  input wire logic              int_mem_en,
  input wire logic              memory_select_bit,
  input wire logic              busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic step;    // Accepted step
  logic cfg;     // Config register addressed
  logic stall_q; // Step right after the absent-input branch is refused
  // Busy lags the stall by a cycle, so the refused step is tracked here
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= step && req.cmd == psq_pkg::PSQ_BRANCH_ON_INPUT_LOW;
    end
  end
  assign step = output_clock_fall && !stall_q;
  assign cfg  = io.bank == psq_pkg::SYSCON_BANK && io.port == psq_pkg::SYSCON_PORT;
  a_reset_clear: assert property (
    $fell(sys_rst) |-> prog_addr == 12'h000 && port_addr_lines == 3'h0)
    else $error("address not zero after reset");
  a_jump_target: assert property (
    step && (req.cmd == psq_pkg::PSQ_CALL || (req.cmd == psq_pkg::PSQ_BRANCH && req.cond))
    |-> ##2 prog_addr == $past(req.target, 2)) else $error("jump target not loaded");
  a_mode_switch: assert property (
    io.we && cfg |-> ##4 memory_select_bit == $past(io.data[0], 4))
    else $error("mode bit not switched");
  a_mode_hold: assert property (
    io.we && cfg |-> ##1 $stable(memory_select_bit)) else $error("mode switched early");
  a_cfg_read: assert property (
    io_rd && cfg |=> io_rdata == {15'h7fff, $past(memory_select_bit)})
    else $error("config read wrong");
  a_read_other: assert property (
    io_rd && !cfg |=> io_rdata == 16'h0000) else $error("unmapped read not zero");
  a_mode_mirror: assert property (
    int_mem_en == memory_select_bit) else $error("memory enable differs from mode");
  a_upper_ones: assert property (
    int_mem_en && $past(int_mem_en) |-> ext_addr_bus == 9'h1ff)
    else $error("upper lines not high");
  a_nmi_single: assert property (
    nmi_pulse |-> !nonmaskable_mode_pin ##1 !nmi_pulse) else $error("bad interrupt pulse");
  a_branch_on_input_low_stall: assert property (
    step && req.cmd == psq_pkg::PSQ_BRANCH_ON_INPUT_LOW |-> ##2 busy) else $error("no stall after no-op");
  c_call: cover property (step && req.cmd == psq_pkg::PSQ_CALL);
  c_cfg: cover property (io.we && cfg);
  c_nmi: cover property (nmi_pulse);
endmodule
bind psq_sequencer psq_checker u_chk (.clock(clock), .sys_rst(sys_rst),
  .output_clock_fall(output_clock_fall), .req(req), .io(io), .io_rd(io_rd),
  .nonmaskable_mode_pin(nonmaskable_mode_pin), .io_rdata(io_rdata), .nmi_pulse(nmi_pulse),
  .prog_addr(prog_addr), .ext_addr_bus(ext_addr_bus), .port_addr_lines(port_addr_lines),
  .int_mem_en(int_mem_en), .memory_select_bit(memory_select_bit), .busy(busy));
`default_nettype wire

// file: tb/program_sequencer_stack_mode_test.sv
// Testbench: program counter, stack and memory mode
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_stack_mode_test;
  typedef struct packed {
    psq_pkg::psq_cmd_t c;
    logic              cd;
    logic [11:0]       t;
    logic [11:0]       a;
    logic [11:0]       pc;
  } psq_row_t;
  logic              clock, sys_rst, step_en, io_rd, pin, seen;
  psq_pkg::psq_req_t req;
  psq_pkg::psq_io_t  io;
  logic [11:0]       acc, prog_addr, pop_data;
  logic [11:0]       tbl, r;
  logic [15:0]       io_rdata, word;
  logic [8:0]        ext_addr_bus;
  logic [2:0]        port_addr_lines;
  logic              nmi_pulse, int_mem_en, memory_select_bit, pop_valid, busy;
  int                fail_count, n_tests;
  // Ordinary flow: branch, fall through, call, push, pop, return
  psq_row_t rows [7] = '{
    '{psq_pkg::PSQ_BRANCH, 1'b1, 12'habc, 12'h000, 12'habc},
    '{psq_pkg::PSQ_BRANCH, 1'b0, 12'h0ff, 12'h000, 12'habd},
    '{psq_pkg::PSQ_CALL,   1'b1, 12'h123, 12'h000, 12'h123},
    '{psq_pkg::PSQ_PUSH,   1'b0, 12'h000, 12'h555, 12'h124},
    '{psq_pkg::PSQ_POP,    1'b0, 12'h000, 12'h000, 12'h125},
    '{psq_pkg::PSQ_RET,    1'b0, 12'h000, 12'h000, 12'habe},
    '{psq_pkg::PSQ_NONE,   1'b0, 12'h000, 12'h000, 12'habf}};
  psq_sequencer DUT (.clock(clock), .sys_rst(sys_rst), .output_clock_fall(step_en),
    .req(req), .acc_low(acc), .tbl_addr(tbl), .io(io), .io_rd(io_rd),
    .io_rdata(io_rdata), .nonmaskable_mode_pin(pin), .nmi_pulse(nmi_pulse),
    .prog_addr(prog_addr), .ext_addr_bus(ext_addr_bus), .port_addr_lines(port_addr_lines),
    .int_mem_en(int_mem_en), .memory_select_bit(memory_select_bit), .pop_data(pop_data),
    .pop_valid(pop_valid), .busy(busy));
  psq_prog_mem u_mem (.clock(clock), .prog_addr(prog_addr), .int_mem_en(int_mem_en),
    .word(word));
  // Compare and count
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Drive one step request at the falling edge
  task automatic go(psq_pkg::psq_cmd_t c, logic cd, logic [11:0] t, logic [11:0] a, logic en);
    @(negedge clock);
    req.cmd = c;
    req.cond = cd;
    req.target = t;
    acc = a;
    step_en = en;
  endtask
  // One step, then let everything settle
  task automatic run(psq_pkg::psq_cmd_t c, logic cd, logic [11:0] t, logic [11:0] a);
    go(c, cd, t, a, 1'b1);
    go(psq_pkg::PSQ_NONE, 1'b0, 12'h000, 12'h000, 1'b0);
    repeat (3) @(negedge clock);
  endtask
  // Port write with upper bits as ones, then idle cycles for the switch
  task automatic cfg_wr(logic [15:0] bank, logic [15:0] d);
    @(negedge clock);
    io = '{1'b1, bank, 3'h3, d};
    @(negedge clock);
    io.we = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  task automatic cfg_rd(logic [15:0] bank, logic [15:0] exp);
    @(negedge clock);
    io.bank = bank;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    check("io_rdata", exp, io_rdata);
  endtask
  task automatic do_reset(logic p);
    pin = p;
    sys_rst = 1'b1;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // Look for an interrupt pulse over a few cycles
  task automatic watch(logic exp);
    seen = 1'b0;
    repeat (5) @(negedge clock) seen |= nmi_pulse;
    check("nmi_pulse", {15'h0, exp}, {15'h0, seen});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Clock at 40 ns
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Watchdog
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {sys_rst, step_en, io_rd, pin, acc, req, io} = '0;
    tbl = 12'h3c0;
    sys_rst = 1'b1;
    do_reset(1'b0);
    check("int_mem_en", 16'h0, {15'h0, int_mem_en});
    check("prog_addr", 16'h0, {4'h0, prog_addr});
    for (int i = 0; i < 7; i++) begin
      run(rows[i].c, rows[i].cd, rows[i].t, rows[i].a);
      check("prog_addr", {4'h0, rows[i].pc}, {4'h0, prog_addr});
      check("ext_addr_bus", {7'h0, rows[i].pc[11:3]}, {7'h0, ext_addr_bus});
      check("port_addr_lines", {13'h0, rows[i].pc[2:0]}, {13'h0, port_addr_lines});
      if (rows[i].c == psq_pkg::PSQ_POP) check("pop_data", 16'h0555, {4'h0, pop_data});
    end
    // External memory answers the settled address
    check("word", {4'h0, prog_addr} ^ 16'h5a5a, word);
    // Interrupt pushes the next address; return comes back to it
    r = prog_addr;
    run(psq_pkg::PSQ_INTR, 1'b0, 12'h010, 12'h000);
    check("prog_addr", 16'h0010, {4'h0, prog_addr});
    run(psq_pkg::PSQ_RET, 1'b0, 12'h000, 12'h000);
    check("prog_addr", {4'h0, r + 12'h001}, {4'h0, prog_addr});
    // Table transfer borrows one level and marks busy
    r = prog_addr;
    run(psq_pkg::PSQ_TBL_START, 1'b0, 12'h000, 12'h000);
    check("prog_addr", 16'h03c0, {4'h0, prog_addr});
    check("busy", 16'h1, {15'h0, busy});
    run(psq_pkg::PSQ_TBL_END, 1'b0, 12'h000, 12'h000);
    check("prog_addr", {4'h0, r + 12'h001}, {4'h0, prog_addr});
    check("busy", 16'h0, {15'h0, busy});
    // Five pushes lose the first; pops then stick at the bottom value
    for (int i = 1; i <= 5; i++) run(psq_pkg::PSQ_PUSH, 1'b0, 12'h000, 12'(i));
    for (int i = 0; i < 6; i++) begin
      run(psq_pkg::PSQ_POP, 1'b0, 12'h000, 12'h000);
      check("pop_data", (i < 3) ? 16'(5 - i) : 16'h2, {4'h0, pop_data});
    end
    // Step right after the absent-input branch is ignored
    go(psq_pkg::PSQ_BRANCH_ON_INPUT_LOW, 1'b0, 12'h000, 12'h000, 1'b1);
    go(psq_pkg::PSQ_BRANCH, 1'b1, 12'hfff, 12'h000, 1'b1);
    run(psq_pkg::PSQ_NONE, 1'b0, 12'h000, 12'h000);
    check("refused branch", 16'h1, {15'h0, prog_addr !== 12'hfff});
    // Mode writes: right place, wrong bank, back to external
    cfg_wr(16'h0001, 16'hffff);
    check("memory_select_bit", 16'h1, {15'h0, memory_select_bit});
    check("ext_addr_bus", 16'h01ff, {7'h0, ext_addr_bus});
    cfg_rd(16'h0001, 16'hffff);
    cfg_wr(16'h0000, 16'hfffe);
    check("memory_select_bit", 16'h1, {15'h0, memory_select_bit});
    cfg_rd(16'h0000, 16'h0000);
    cfg_wr(16'h0001, 16'hfffe);
    check("int_mem_en", 16'h0, {15'h0, int_mem_en});
    // Pin raised after reset gives nothing; a fall interrupts
    pin = 1'b1;
    watch(1'b0);
    do_reset(1'b1);
    check("int_mem_en", 16'h1, {15'h0, int_mem_en});
    pin = 1'b0;
    watch(1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
